// File: hdl/spdm_pkg.sv
package spdm_pkg;
  // register indices, byte address is four times the index
  localparam logic [5:0] IDX_OVERSAMPLE = 6'h0a;
  localparam logic [5:0] IDX_POWER      = 6'h12;
  localparam logic [5:0] IDX_VOL_LEFT   = 6'h24;
  localparam logic [5:0] IDX_VOL_RIGHT  = 6'h25;
  localparam logic [5:0] IDX_INPUT_CTRL = 6'h27;
  localparam logic [5:0] IDX_STATUS     = 6'h28;

  // field positions
  localparam int BIT_OVERSAMPLE = 0;
  localparam int BIT_LEFT_EN    = 1;
  localparam int BIT_RIGHT_EN   = 0;
  localparam int BIT_VOL_UPDATE = 8;
  localparam int BIT_MODE       = 12;
  localparam int BIT_PIN_SEL    = 11;

  // reset values and gain code ceiling
  localparam logic       RST_OVERSAMPLE = 1'b1;
  localparam logic [7:0] RST_GAIN_CODE  = 8'hc0;
  localparam logic [7:0] GAIN_CODE_MAX  = 8'hef;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // bit clock timing: fastest allowed bit clock sets the half period
  localparam int SYS_CLK_HZ     = 25_000_000;
  localparam int MIC_CLK_MAX_HZ = 3_000_000;
  localparam int MIC_CLK_MIN_HZ = 1_000_000;
  localparam int MIC_HALF_CYC   = (SYS_CLK_HZ + 2 * MIC_CLK_MAX_HZ - 1) / (2 * MIC_CLK_MAX_HZ);
  localparam int SYNC_STAGES    = 2;
  localparam int MIC_SAMPLE_AT  = MIC_HALF_CYC / 2 + SYNC_STAGES;
  localparam int DIV_W          = 3;
  localparam int OVERSAMPLE     = 64;
endpackage : spdm_pkg

// File: hdl/spdm_decim.sv
`timescale 1ns/1ps
module spdm_decim
  import spdm_pkg::*;
#(
  parameter int DECIM = OVERSAMPLE
) (
  // clock and reset
  input  wire logic               clk_sys_i,
  input  wire logic               srst_i,
  // bit stream in
  input  wire logic               en_i,
  input  wire logic               bit_valid_i,
  input  wire logic               bit_i,
  // pcm out
  output logic                    pcm_valid_o,
  output logic signed [15:0]      pcm_o
);
  localparam int CW = $clog2(DECIM);
  localparam int OW = $clog2(DECIM + 1);

  typedef struct packed {
    logic [CW-1:0]      cnt;
    logic [OW-1:0]      ones;
    logic               out_v;
    logic signed [15:0] out;
  } spdm_dec_s;

  spdm_dec_s st_r, st_nxt;
  logic signed [16:0] level;

  // boxcar count of ones over one decimation window
  always_comb begin
    st_nxt = st_r;
    st_nxt.out_v = 1'b0;
    level = 17'(st_r.ones + 17'(bit_i)) <<< (16 - CW);
    level = level - 17'sh08000;
    if (!en_i) begin
      st_nxt.cnt = '0;
      st_nxt.ones = '0;
    end else if (bit_valid_i) begin
      if (st_r.cnt == CW'(DECIM - 1)) begin
        st_nxt.cnt = '0;
        st_nxt.ones = '0;
        st_nxt.out_v = 1'b1;
        st_nxt.out = (level > 17'sh07fff) ? 16'sh7fff : level[15:0];
      end else begin
        st_nxt.cnt = st_r.cnt + 1'b1;
        st_nxt.ones = st_r.ones + OW'(bit_i);
      end
    end
    if (srst_i) begin
      st_nxt = '0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    st_r <= st_nxt;
  end

  assign pcm_valid_o = st_r.out_v;
  assign pcm_o       = st_r.out;
endmodule : spdm_decim

// File: hdl/spdm_gain.sv
`timescale 1ns/1ps
module spdm_gain
  import spdm_pkg::*;
(
  // gain code
  input  wire logic [7:0]         code_i,
  // samples
  input  wire logic signed [15:0] pcm_i,
  output logic signed [15:0]      pcm_o
);
  // 2^(k*0.375/6.02) in q2.14, one entry per step inside an octave
  localparam logic [15:0] MANT [16] = '{
    16'h4000, 16'h42d3, 16'h45c6, 16'h48db, 16'h4c11, 16'h4f6d, 16'h52ef, 16'h5698,
    16'h5a6a, 16'h5e68, 16'h6293, 16'h66ed, 16'h6b78, 16'h7037, 16'h752b, 16'h7a57
  };

  logic [7:0]         code;
  logic signed [32:0] prod;
  logic signed [40:0] wide;
  logic [4:0]         sh;

  // code c0 is unity; sixteen steps make one octave
  always_comb begin
    code = (code_i > GAIN_CODE_MAX) ? GAIN_CODE_MAX : code_i;
    prod = pcm_i * $signed({1'b0, MANT[code[3:0]]});
    sh   = 5'd28 - 5'(code[7:4]);
    wide = (41'(prod) <<< 2) >>> sh;
    if (code_i == 8'h00) begin
      pcm_o = '0;
    end else if (wide > 41'sh07fff) begin
      pcm_o = 16'sh7fff;
    end else if (wide < -41'sh08000) begin
      pcm_o = -16'sh8000;
    end else begin
      pcm_o = wide[15:0];
    end
  end
endmodule : spdm_gain

// File: hdl/spdm_top.sv
// Functional notes
// - pin select bit picks data pin a/b
// - mode bit routes mic path to dsp
// - mode off holds bit clock low
// - left/right dsp enables, reset disabled
// - bit clock multiple of fs, 1-3 MHz
// - both channels share one selected pin
// - sample mid-phase; high left, low right
// - gain code map, mute at zero
// - volume codes reset to c0 (0 dB)
// - write without update keeps applied gain
// - update bit applies both gains together
`timescale 1ns/1ps
module spdm_top
  import spdm_pkg::*;
(
  // clock and reset
  input  wire logic               clk_sys_i,
  input  wire logic               srst_i,
  // axi4-lite write address and data
  input  wire logic [7:0]         s_axi_awaddr_i,
  input  wire logic               s_axi_awvalid_i,
  output logic                    s_axi_awready_o,
  input  wire logic [31:0]        s_axi_wdata_i,
  input  wire logic [3:0]         s_axi_wstrb_i,
  input  wire logic               s_axi_wvalid_i,
  output logic                    s_axi_wready_o,
  // axi4-lite write response
  output logic [1:0]              s_axi_bresp_o,
  output logic                    s_axi_bvalid_o,
  input  wire logic               s_axi_bready_i,
  // axi4-lite read
  input  wire logic [7:0]         s_axi_araddr_i,
  input  wire logic               s_axi_arvalid_i,
  output logic                    s_axi_arready_o,
  output logic [31:0]             s_axi_rdata_o,
  output logic [1:0]              s_axi_rresp_o,
  output logic                    s_axi_rvalid_o,
  input  wire logic               s_axi_rready_i,
  // microphone pins
  output logic                    mic_bit_clock_o,
  input  wire logic               mic_data_pin_a_i,
  input  wire logic               mic_data_pin_b_i,
  // analogue path samples
  input  wire logic signed [15:0] analog_left_i,
  input  wire logic signed [15:0] analog_right_i,
  input  wire logic               analog_valid_i,
  // audio dsp input
  output logic signed [15:0]      pcm_left_o,
  output logic                    pcm_left_valid_o,
  output logic signed [15:0]      pcm_right_o,
  output logic                    pcm_right_valid_o
);
  typedef struct packed {
    logic [1:0]         sync_a;
    logic [1:0]         sync_b;
    logic [DIV_W-1:0]   div_cnt;
    logic               clk_lvl;
    logic [1:0]         bit_v;
    logic [1:0]         bit_d;
    logic               osr;
    logic               pwr_l;
    logic               pwr_r;
    logic               mode;
    logic               pin_sel;
    logic [7:0]         vol_l;
    logic [7:0]         vol_r;
    logic [7:0]         app_l;
    logic [7:0]         app_r;
    logic               awready;
    logic [5:0]         aw_idx;
    logic               wready;
    logic [31:0]        wdata;
    logic [3:0]         wstrb;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               arready;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
    logic signed [15:0] pcm_l;
    logic               pcm_lv;
    logic signed [15:0] pcm_r;
    logic               pcm_rv;
  } spdm_top_s;

  spdm_top_s st_r, st_nxt;

  logic [1:0]         dec_en;
  logic [1:0]         dec_v;
  logic signed [15:0] dec_pcm [2];
  logic signed [15:0] gain_pcm [2];
  logic [7:0]         app_code [2];
  logic               wr_fire;
  logic               hit;
  logic               pick;

  // decimation and gain per channel, 0 left and 1 right
  assign dec_en[0]   = st_r.pwr_l & st_r.mode & ~st_r.osr;
  assign dec_en[1]   = st_r.pwr_r & st_r.mode & ~st_r.osr;
  assign app_code[0] = st_r.app_l;
  assign app_code[1] = st_r.app_r;

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    spdm_decim #(
      .DECIM       (OVERSAMPLE)
    ) u_decim (
      .clk_sys_i   (clk_sys_i),
      .srst_i      (srst_i),
      .en_i        (dec_en[ch]),
      .bit_valid_i (st_r.bit_v[ch]),
      .bit_i       (st_r.bit_d[ch]),
      .pcm_valid_o (dec_v[ch]),
      .pcm_o       (dec_pcm[ch])
    );
    spdm_gain u_gain (
      .code_i      (app_code[ch]),
      .pcm_i       (dec_pcm[ch]),
      .pcm_o       (gain_pcm[ch])
    );
  end

  // register read mux
  function automatic logic [33:0] rd_word(input logic [5:0] idx, input spdm_top_s s);
    logic [31:0] d;
    logic [1:0]  r;
    d = '0;
    r = RESP_OKAY;
    case (idx)
      IDX_OVERSAMPLE: d[BIT_OVERSAMPLE] = s.osr;
      IDX_POWER: begin
        d[BIT_LEFT_EN]  = s.pwr_l;
        d[BIT_RIGHT_EN] = s.pwr_r;
      end
      IDX_VOL_LEFT:   d[7:0] = s.vol_l;
      IDX_VOL_RIGHT:  d[7:0] = s.vol_r;
      IDX_INPUT_CTRL: begin
        d[BIT_MODE]    = s.mode;
        d[BIT_PIN_SEL] = s.pin_sel;
      end
      IDX_STATUS:     d[15:0] = {s.app_r, s.app_l};
      default:        r = RESP_SLVERR;
    endcase
    return {r, d};
  endfunction : rd_word

  assign wr_fire = ~st_r.awready & ~st_r.wready & ~st_r.bvalid;
  assign hit     = (st_r.div_cnt == DIV_W'(MIC_SAMPLE_AT));
  assign pick    = st_r.pin_sel ? st_r.sync_b[1] : st_r.sync_a[1];

  always_comb begin
    st_nxt = st_r;
    // pin synchronisers
    st_nxt.sync_a = {st_r.sync_a[0], mic_data_pin_a_i};
    st_nxt.sync_b = {st_r.sync_b[0], mic_data_pin_b_i};

    // bit clock divider, held low while mode is off
    if (!st_r.mode) begin
      st_nxt.div_cnt = '0;
      st_nxt.clk_lvl = 1'b0;
    end else if (st_r.div_cnt == DIV_W'(MIC_HALF_CYC - 1)) begin
      st_nxt.div_cnt = '0;
      st_nxt.clk_lvl = ~st_r.clk_lvl;
    end else begin
      st_nxt.div_cnt = st_r.div_cnt + 1'b1;
    end

    // mid-phase sample, corrected for synchroniser delay
    st_nxt.bit_v[0] = st_r.mode & st_r.clk_lvl & hit;
    st_nxt.bit_v[1] = st_r.mode & ~st_r.clk_lvl & hit;
    st_nxt.bit_d    = {pick, pick};

    // dsp input source
    if (st_r.mode) begin
      st_nxt.pcm_lv = dec_v[0];
      st_nxt.pcm_rv = dec_v[1];
      if (dec_v[0]) begin
        st_nxt.pcm_l = gain_pcm[0];
      end
      if (dec_v[1]) begin
        st_nxt.pcm_r = gain_pcm[1];
      end
    end else begin
      st_nxt.pcm_lv = analog_valid_i;
      st_nxt.pcm_rv = analog_valid_i;
      if (analog_valid_i) begin
        st_nxt.pcm_l = analog_left_i;
        st_nxt.pcm_r = analog_right_i;
      end
    end

    // write address and data, taken in either order
    if (s_axi_awvalid_i && st_r.awready) begin
      st_nxt.awready = 1'b0;
      st_nxt.aw_idx  = s_axi_awaddr_i[7:2];
    end
    if (s_axi_wvalid_i && st_r.wready) begin
      st_nxt.wready = 1'b0;
      st_nxt.wdata  = s_axi_wdata_i;
      st_nxt.wstrb  = s_axi_wstrb_i;
    end

    // register write once both halves are held
    if (wr_fire) begin
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = RESP_OKAY;
      case (st_r.aw_idx)
        IDX_OVERSAMPLE: if (st_r.wstrb[0]) st_nxt.osr = st_r.wdata[BIT_OVERSAMPLE];
        IDX_POWER: if (st_r.wstrb[0]) begin
          st_nxt.pwr_l = st_r.wdata[BIT_LEFT_EN];
          st_nxt.pwr_r = st_r.wdata[BIT_RIGHT_EN];
        end
        IDX_VOL_LEFT:  if (st_r.wstrb[0]) st_nxt.vol_l = st_r.wdata[7:0];
        IDX_VOL_RIGHT: if (st_r.wstrb[0]) st_nxt.vol_r = st_r.wdata[7:0];
        IDX_INPUT_CTRL: if (st_r.wstrb[1]) begin
          st_nxt.mode    = st_r.wdata[BIT_MODE];
          st_nxt.pin_sel = st_r.wdata[BIT_PIN_SEL];
        end
        IDX_STATUS: ;
        default: st_nxt.bresp = RESP_SLVERR;
      endcase
      // update bit applies both stored codes at once
      if ((st_r.aw_idx == IDX_VOL_LEFT || st_r.aw_idx == IDX_VOL_RIGHT)
          && st_r.wstrb[1] && st_r.wdata[BIT_VOL_UPDATE]) begin
        st_nxt.app_l = st_nxt.vol_l;
        st_nxt.app_r = st_nxt.vol_r;
      end
    end
    if (st_r.bvalid && s_axi_bready_i) begin
      st_nxt.bvalid  = 1'b0;
      st_nxt.awready = 1'b1;
      st_nxt.wready  = 1'b1;
    end

    // read channel, one outstanding
    if (s_axi_arvalid_i && st_r.arready) begin
      st_nxt.arready = 1'b0;
      st_nxt.rvalid  = 1'b1;
      {st_nxt.rresp, st_nxt.rdata} = rd_word(s_axi_araddr_i[7:2], st_r);
    end
    if (st_r.rvalid && s_axi_rready_i) begin
      st_nxt.rvalid  = 1'b0;
      st_nxt.arready = 1'b1;
    end

    // synchronous reset
    if (srst_i) begin
      st_nxt         = '0;
      st_nxt.osr     = RST_OVERSAMPLE;
      st_nxt.vol_l   = RST_GAIN_CODE;
      st_nxt.vol_r   = RST_GAIN_CODE;
      st_nxt.app_l   = RST_GAIN_CODE;
      st_nxt.app_r   = RST_GAIN_CODE;
      st_nxt.awready = 1'b1;
      st_nxt.wready  = 1'b1;
      st_nxt.arready = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    st_r <= st_nxt;
  end

  // outputs straight from the state register
  assign s_axi_awready_o   = st_r.awready;
  assign s_axi_wready_o    = st_r.wready;
  assign s_axi_bresp_o     = st_r.bresp;
  assign s_axi_bvalid_o    = st_r.bvalid;
  assign s_axi_arready_o   = st_r.arready;
  assign s_axi_rdata_o     = st_r.rdata;
  assign s_axi_rresp_o     = st_r.rresp;
  assign s_axi_rvalid_o    = st_r.rvalid;
  assign mic_bit_clock_o   = st_r.clk_lvl;
  assign pcm_left_o        = st_r.pcm_l;
  assign pcm_left_valid_o  = st_r.pcm_lv;
  assign pcm_right_o       = st_r.pcm_r;
  assign pcm_right_valid_o = st_r.pcm_rv;

  // checks on the design's own behaviour
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  a_clk_held_low: assert property (!st_r.mode |=> !mic_bit_clock_o)
    else $error("bit clock not low while mode off");
  a_clk_half_len: assert property (($rose(mic_bit_clock_o) && st_r.mode)
    |-> (mic_bit_clock_o || !st_r.mode)[*5])
    else $error("bit clock high phase too short");
  a_clk_toggles: assert property ((st_r.mode && mic_bit_clock_o)
    |-> ##[1:5] (!mic_bit_clock_o))
    else $error("bit clock high phase too long");
  a_left_high: assert property (st_r.bit_v[0] |-> $past(st_r.clk_lvl) && !st_r.bit_v[1])
    else $error("left sample outside high phase");
  a_right_low: assert property (st_r.bit_v[1] |-> !$past(st_r.clk_lvl))
    else $error("right sample outside low phase");
  a_mid_phase: assert property ((st_r.bit_v != 2'b00)
    |-> $past(st_r.div_cnt) == DIV_W'(MIC_SAMPLE_AT))
    else $error("sample not at phase midpoint");
  a_src_pick: assert property ((st_r.bit_v[0] && $past(st_r.pin_sel))
    |-> st_r.bit_d[0] == $past(st_r.sync_b[1]))
    else $error("data not taken from pin b");
  a_vol_reset: assert property ($fell(srst_i) |-> st_r.vol_l == RST_GAIN_CODE
    && st_r.app_r == RST_GAIN_CODE)
    else $error("volume reset value wrong");
  a_vu_hold: assert property ((wr_fire && !(st_r.wstrb[1] && st_r.wdata[BIT_VOL_UPDATE]))
    |=> $stable(st_r.app_l) && $stable(st_r.app_r))
    else $error("applied gain changed without update");
  a_vu_apply: assert property ((wr_fire && st_r.aw_idx == IDX_VOL_RIGHT && st_r.wstrb[1]
    && st_r.wdata[BIT_VOL_UPDATE]) |=> st_r.app_l == st_r.vol_l && st_r.app_r == st_r.vol_r)
    else $error("update did not apply both gains");
  a_dsp_off: assert property ((!st_r.pwr_l && st_r.mode)[*3] |-> !pcm_left_valid_o)
    else $error("left output while disabled");
  a_mute_zero: assert property ((pcm_left_valid_o && $past(st_r.mode)
    && $past(st_r.app_l) == 8'h00) |-> pcm_left_o == 16'sh0000)
    else $error("mute code gave nonzero sample");

  // routing checks: pins a and b feed the right channel, and the dsp input follows the mode bit, then right-off and bit clock checks;
  // a broken pin mux shows up here at bit_d, before the pcm outputs; a stale source shows up at the pcm outputs themselves
  a_pin_a_pick: assert property ((st_r.bit_v[1] && !$past(st_r.pin_sel))
    |-> st_r.bit_d[1] == $past(st_r.sync_a[1]))
    else $error("data not taken from pin a");
  a_right_pin_b: assert property ((st_r.bit_v[1] && $past(st_r.pin_sel))
    |-> st_r.bit_d[1] == $past(st_r.sync_b[1]))
    else $error("right data not taken from pin b");
  a_analog_pass: assert property ((!st_r.mode && analog_valid_i)
    |=> pcm_left_valid_o && pcm_left_o == $past(analog_left_i))
    else $error("analogue sample not passed on");
  a_mic_source: assert property ($past(st_r.mode)
    |-> pcm_left_valid_o == $past(dec_v[0]))
    else $error("dsp input not from mic path");
  a_right_off: assert property ((!st_r.pwr_r && st_r.mode)[*3]
    |-> !pcm_right_valid_o)
    else $error("right output while disabled");
  a_clk_low_len: assert property (($fell(mic_bit_clock_o) && st_r.mode)
    |-> (!mic_bit_clock_o || !st_r.mode)[*5])
    else $error("bit clock low phase too short");
  a_clk_start_low: assert property ($rose(st_r.mode)
    |-> !mic_bit_clock_o)
    else $error("bit clock not low at mode start");
endmodule : spdm_top

// File: tb/spdm_mic_pair.sv
`timescale 1ns/1ps
module spdm_mic_pair (
  // bit clock from the receiver
  input  wire logic mic_bit_clock_i,
  // constant bit levels of the two microphones
  input  wire logic left_bit_i,
  input  wire logic right_bit_i,
  // shared data line
  output wire       mic_data_line_o
);
  // left talks in the high phase, right in the low phase, idle side floats
  assign mic_data_line_o = mic_bit_clock_i ? left_bit_i : 1'bz;
  assign mic_data_line_o = !mic_bit_clock_i ? right_bit_i : 1'bz;
endmodule : spdm_mic_pair

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import spdm_pkg::*;
  logic               clk, srst, awvalid, wvalid, bready, arvalid, rready, avalid;
  logic [7:0]         awaddr, araddr;
  logic [31:0]        wdata, rdata, d;
  logic [3:0]         wstrb;
  logic [1:0]         bresp, rresp, resp;
  logic               awready, wready, bvalid, arready, rvalid, bclk, lv, rv;
  logic signed [15:0] al, ar_s, pl, pr;
  wire                pin_a, pin_b;
  int                 miscompares, total_checks, n;
  time                t0;
  localparam logic [7:0] A_OSR = {IDX_OVERSAMPLE, 2'b00};
  localparam logic [7:0] A_PWR = {IDX_POWER, 2'b00};
  localparam logic [7:0] A_VL  = {IDX_VOL_LEFT, 2'b00};
  localparam logic [7:0] A_VR  = {IDX_VOL_RIGHT, 2'b00};
  localparam logic [7:0] A_IC  = {IDX_INPUT_CTRL, 2'b00};
  localparam logic [7:0] A_ST  = {IDX_STATUS, 2'b00};

  // pin a carries left ones / right zeros, pin b the opposite
  spdm_mic_pair u_mic_a (.mic_bit_clock_i(bclk), .left_bit_i(1'b1), .right_bit_i(1'b0),
                         .mic_data_line_o(pin_a));
  spdm_mic_pair u_mic_b (.mic_bit_clock_i(bclk), .left_bit_i(1'b0), .right_bit_i(1'b1),
                         .mic_data_line_o(pin_b));

  spdm_top u_dut (
    .clk_sys_i(clk), .srst_i(srst),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .mic_bit_clock_o(bclk), .mic_data_pin_a_i(pin_a), .mic_data_pin_b_i(pin_b),
    .analog_left_i(al), .analog_right_i(ar_s), .analog_valid_i(avalid),
    .pcm_left_o(pl), .pcm_left_valid_o(lv), .pcm_right_o(pr), .pcm_right_valid_o(rv)
  );

  // system clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict

  // write: address and data offered together, each released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (!aw_ok && awready) begin aw_ok = 1'b1; awvalid <= 1'b0; end
      if (!w_ok && wready) begin w_ok = 1'b1; wvalid <= 1'b0; end
    end
    while (!bvalid) @(posedge clk);
    resp = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    @(posedge clk);
    while (!arready) @(posedge clk);
    arvalid <= 1'b0;
    @(posedge clk);
    while (!rvalid) @(posedge clk);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  // waits for one sample pulse of a channel, result in d
  task automatic wait_pcm(input bit left_ch);
    do @(negedge clk); while (!(left_ch ? lv : rv));
    d = left_ch ? {16'h0, pl} : {16'h0, pr};
  endtask : wait_pcm

  task automatic count_bclk_high();
    n = 0;
    repeat (50) begin
      @(negedge clk);
      if (bclk !== 1'b0) n++;
    end
  endtask : count_bclk_high

  // hang guard
  initial begin
    #(40 * 40000);
    miscompares++;
    print_verdict();
  end

  initial begin
    srst = 1'b1; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; avalid = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
    wstrb = 4'h3; al = 16'sh0; ar_s = 16'sh0;
    miscompares = 0; total_checks = 0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    // reset values and refused accesses
    axi_rd(A_OSR); chk("oversample reset", 32'h1, d);
    axi_rd(A_PWR); chk("enables reset", 32'h0, d);
    axi_rd(A_VL); chk("left code reset", 32'hc0, d);
    chk("read resp okay", {30'h0, RESP_OKAY}, {30'h0, resp});
    axi_rd(A_VR); chk("right code reset", 32'hc0, d);
    axi_rd(A_IC); chk("input ctrl reset", 32'h0, d);
    axi_rd(8'hfc); chk("unmapped read resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
    axi_wr(8'hfc, 32'hffff); chk("unmapped write resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
    // mode off: clock held low, analogue samples pass through
    count_bclk_high(); chk("idle bit clock", 32'h0, n);
    @(posedge clk);
    al <= 16'sh1234; ar_s <= -16'sh0235; avalid <= 1'b1;
    @(posedge clk);
    avalid <= 1'b0; // analogue samples stay idle once mics are in use
    @(negedge clk);
    chk("analog left", 32'h1234, {16'h0, pl});
    chk("analog right", 32'hfdcb, {16'h0, pr});
    chk("analog valid", 32'h1, {31'h0, lv});
    // staged gain codes and simultaneous update
    axi_wr(A_VL, 32'h40);
    chk("write resp okay", {30'h0, RESP_OKAY}, {30'h0, resp});
    axi_rd(A_ST); chk("applied after stage", 32'hc0c0, d);
    axi_rd(A_VL); chk("stored left code", 32'h40, d);
    axi_wr(A_VR, 32'h180);
    axi_rd(A_ST); chk("applied after update", 32'h8040, d);
    axi_wr(A_VR, 32'hc0);
    axi_wr(A_VL, 32'h1c0);
    axi_rd(A_ST); chk("unity applied", 32'hc0c0, d);
    // microphone path on pin a
    axi_wr(A_OSR, 32'h0);
    axi_wr(A_PWR, 32'h3);
    axi_wr(A_IC, 32'h1000);
    @(negedge clk);
    while (bclk) @(negedge clk);
    while (!bclk) @(negedge clk);
    n = 0;
    do begin @(negedge clk); n++; end while (bclk);
    do begin @(negedge clk); n++; end while (!bclk);
    chk("bit clock range", 32'h1, {31'h0, (n >= 9 && n <= 25)});
    wait_pcm(1'b1);
    t0 = $time;
    wait_pcm(1'b1); chk("left all ones", 32'h7fff, d);
    chk("sample spacing", 64 * n, 32'(($time - t0) / 40));
    wait_pcm(1'b0); wait_pcm(1'b0); chk("right all zeros", 32'h8000, d);
    // pin b carries the opposite pattern
    axi_wr(A_IC, 32'h1800);
    wait_pcm(1'b1); wait_pcm(1'b1); chk("left from pin b", 32'h8000, d);
    wait_pcm(1'b0); wait_pcm(1'b0); chk("right from pin b", 32'h7fff, d);
    // mute code on left only
    axi_wr(A_VL, 32'h100);
    wait_pcm(1'b1); wait_pcm(1'b1); chk("left muted", 32'h0, d);
    wait_pcm(1'b0); wait_pcm(1'b0); chk("right still unity", 32'h7fff, d);
    // code b0 is sixteen steps below unity, 6 dB down: about half of full scale
    axi_wr(A_VR, 32'h1b0);
    wait_pcm(1'b0);
    wait_pcm(1'b0);
    chk("right at minus 6 dB", 32'h1, {31'h0, (d >= 32'h3fc0 && d <= 32'h4040)});
    // both channels disabled: no samples
    axi_wr(A_PWR, 32'h0);
    repeat (10) @(negedge clk);
    n = 0;
    repeat (1500) begin
      @(negedge clk);
      if (lv !== 1'b0 || rv !== 1'b0) n++;
    end
    chk("pulses when disabled", 32'h0, n);
    axi_wr(A_IC, 32'h0);
    repeat (20) @(negedge clk);
    count_bclk_high(); chk("bit clock after mode off", 32'h0, n);
    print_verdict();
  end
endmodule : testbench
